// ### supply_monitor_regs.svh
`ifndef SUPPLY_MONITOR_REGS_SVH
`define SUPPLY_MONITOR_REGS_SVH
// Purpose: register offsets, field positions and reset values of the supply monitor
// Assumes: 32-bit APB data, one aligned word per register
// Notes: definitions only

// byte offsets
`define OFS_MON_STATUS 8'h00
`define OFS_MON_CONFIG 8'h04
`define OFS_EVT_STATUS 8'h08
`define OFS_EVT_ENABLE 8'h0c
`define OFS_EVT_CLEAR 8'h10

// supply_monitor_status fields
`define STS_FLAG_BIT 0
`define STS_RESET_BIT 1
`define STS_ACTIVE_BIT 2

// event fields
`define EVT_WIDTH 3
`define EVT_TRIP_BIT 0
`define EVT_RECOVER_BIT 1
`define EVT_RESET_BIT 2

// reset values
`define CONFIG_RESET 5'h00
`define EVT_ENABLE_RESET 3'h0
`define FLAG_RESET 1'b0

// timing: edges from a committed range write until the synced comparator answers for it
`define RANGE_SETTLE 4

`endif

// ### supply_monitor_pkg.sv
// Purpose: shared types of the supply monitor
// Assumes: bit positions live in supply_monitor_regs.svh
// Notes: config struct order matches the config register, lock in bit 4
package supply_monitor_pkg;

    // write-once configuration word
    typedef struct packed {
        logic lock;
        logic monitor_stop_enable;
        logic range_select;
        logic monitor_reset_disable;
        logic monitor_power_disable;
    } cfg_s;

    // synchronised comparator indications
    typedef struct packed {
        logic below_falling;
        logic above_rising;
    } cmp_s;

    // reset request state
    typedef enum logic [0:0] {
        MON_CLEAR,
        MON_TRIPPED
    } mon_state_e;

endpackage

// ### level_sync.sv
// Purpose: two-stage synchroniser for asynchronous levels
// Assumes: inputs are slow levels, not pulses
// Notes: stage one is read only by stage two
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_r;

    // two flops in series, reset to the idle level
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_r <= '0;
            sync_out <= '0;
        end else begin
            stage1_r <= async_in;
            sync_out <= stage1_r;
        end
    end

endmodule

// ### supply_monitor.sv
// Purpose: digital control of the supply undervoltage monitor
// Assumes: comparator outputs are asynchronous levels; wait/stop come from mclk logic
// Notes: registers reached over APB, answer on the second access cycle
//
// Overview of operation
// - range select clear after reset, low range
// - high range below rising point resets at once
// - reset holds until supply above rising point
// - comparator result drives the undervoltage flag
// - out of reset enabled with resets active
// - power disable stops resets and flag updates
// - reset disable blocks every reset request
// - stop enable keeps monitor running in stop
// - trip below falling point requests system reset
// - flag read-only, set low, cleared high, held between
// - range select lives in write-once config
// - monitor raises no interrupt of its own; the code drives irq from enabled events
// - monitor stays active in wait mode
// - in stop active only when enabled for stop
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`include "supply_monitor_regs.svh"
module supply_monitor (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog comparator, asynchronous levels
    input wire logic below_falling,
    input wire logic above_rising,
    // low-power modes from the system
    input wire logic wait_mode,
    input wire logic stop_mode,
    // outputs
    output logic range_select,
    output logic monitor_enable,
    output logic reset_req,
    output logic undervoltage_flag,
    output logic irq
);
    import supply_monitor_pkg::*;

    supply_monitor_pkg::cfg_s cfg_r;
    supply_monitor_pkg::cmp_s cmp;
    mon_state_e state_r;
    mon_state_e state_nxt;
    logic flag_r;
    logic flag_nxt;
    logic active;
    logic resets_on;
    logic range_new;
    logic acc_done;
    logic wr_cfg;
    logic wr_en;
    logic wr_clr;
    logic [`EVT_WIDTH-1:0] evt_r;
    logic [`EVT_WIDTH-1:0] evt_en_r;
    logic [`EVT_WIDTH-1:0] evt_set;
    logic [`EVT_WIDTH-1:0] evt_clr;
    logic [31:0] rd_data;
    logic rd_err;
    logic live;
    logic [1:0] cmp_ok_r;
    logic [`RANGE_SETTLE-1:0] range_dly_r;

    // decode a word address against one register offset
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr[7:2] == ofs[7:2]);
    endfunction

    // a word address that no register answers
    function automatic logic unmapped(input logic [7:0] addr);
        unmapped = !(hit(addr, `OFS_MON_STATUS) || hit(addr, `OFS_MON_CONFIG) ||
                     hit(addr, `OFS_EVT_STATUS) || hit(addr, `OFS_EVT_ENABLE) ||
                     hit(addr, `OFS_EVT_CLEAR));
    endfunction

    // comparator levels enter the clock domain through two flops
    level_sync #(
        .WIDTH(2)
    ) u_cmp_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in({below_falling, above_rising}),
        .sync_out(cmp)
    );

    // ---------------- apb slave ----------------

    // pready pulses on the second access cycle; one wait state keeps prdata a flop
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    // the access completes at the edge where the master sees pready
    assign acc_done = psel && penable && pready;
    assign wr_cfg = acc_done && pwrite && hit(paddr, `OFS_MON_CONFIG);
    assign wr_en = acc_done && pwrite && hit(paddr, `OFS_EVT_ENABLE);
    assign wr_clr = acc_done && pwrite && hit(paddr, `OFS_EVT_CLEAR);

    // read multiplexer; write-only clear reads zero
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = unmapped(paddr);
        if (hit(paddr, `OFS_MON_STATUS)) begin
            rd_data[`STS_FLAG_BIT] = flag_r;
            rd_data[`STS_RESET_BIT] = reset_req;
            rd_data[`STS_ACTIVE_BIT] = active;
        end else if (hit(paddr, `OFS_MON_CONFIG)) begin
            rd_data[4:0] = cfg_r;
        end else if (hit(paddr, `OFS_EVT_STATUS)) begin
            rd_data[`EVT_WIDTH-1:0] = evt_r;
        end else if (hit(paddr, `OFS_EVT_ENABLE)) begin
            rd_data[`EVT_WIDTH-1:0] = evt_en_r;
        end
    end

    // read data and error are captured with pready so both stand one cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_data;
            pslverr <= rd_err;
        end else begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // ---------------- configuration ----------------

    // write-once: the first write stores and locks, later writes are dropped
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= `CONFIG_RESET;
        end else if (wr_cfg && !cfg_r.lock) begin
            cfg_r <= {1'b1, pwdata[3:0]};
        end
    end

    // one-cycle strobe when the high range is first selected
    assign range_new = wr_cfg && !cfg_r.lock && pwdata[2];

    // the comparator answers for the new range only after the range flop and the sync,
    // so the rising-point test waits for it instead of judging the old range
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            range_dly_r <= '0;
        end else begin
            range_dly_r <= {range_dly_r[`RANGE_SETTLE-2:0], range_new};
        end
    end

    // monitor runs unless powered down, and in stop only when allowed
    assign active = !cfg_r.monitor_power_disable &&
                    (!stop_mode || cfg_r.monitor_stop_enable);
    // wait mode does not appear here: the monitor keeps running through it
    assign resets_on = live && !cfg_r.monitor_reset_disable;

    // a woken comparator is trusted only once its enable has passed the sync depth;
    // otherwise the noise of a sleeping comparator could trip a reset on wake-up
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_ok_r <= 2'b00;
        end else begin
            cmp_ok_r <= {cmp_ok_r[0], monitor_enable};
        end
    end

    assign live = active && cmp_ok_r[1];

    // range and enable go to the analog part straight from flops
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            range_select <= 1'b0;
            monitor_enable <= 1'b1;
        end else begin
            range_select <= cfg_r.range_select;
            monitor_enable <= active;
        end
    end

    // ---------------- undervoltage flag ----------------

    // hysteresis: set below falling point, cleared above rising, held between
    always_comb begin
        flag_nxt = flag_r;
        if (live) begin
            if (cmp.below_falling) begin
                flag_nxt = 1'b1;
            end else if (cmp.above_rising) begin
                flag_nxt = 1'b0;
            end
        end
    end

    // next flag value loads both the status flag register and the pin flop
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= `FLAG_RESET;
            undervoltage_flag <= `FLAG_RESET;
        end else begin
            flag_r <= flag_nxt;
            undervoltage_flag <= flag_nxt;
        end
    end

    // ---------------- reset request ----------------

    // tripped state holds the request until the supply clears the rising point
    always_comb begin
        state_nxt = state_r;
        if (!resets_on) begin
            state_nxt = MON_CLEAR;
        end else begin
            case (state_r)
                MON_CLEAR: begin
                    if (cmp.below_falling) begin
                        state_nxt = MON_TRIPPED;
                    end else if (range_dly_r[`RANGE_SETTLE-1] && !cmp.above_rising) begin
                        state_nxt = MON_TRIPPED;
                    end
                end
                MON_TRIPPED: begin
                    if (cmp.above_rising && !cmp.below_falling) begin
                        state_nxt = MON_CLEAR;
                    end
                end
                default: begin
                    state_nxt = MON_CLEAR;
                end
            endcase
        end
    end

    // the request pin is a flop copy of the next state, so it follows with no lag
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= MON_CLEAR;
            reset_req <= 1'b0;
        end else begin
            state_r <= state_nxt;
            reset_req <= (state_nxt == MON_TRIPPED);
        end
    end

    // ---------------- event summary ----------------

    // events for software only; enables reset to zero so nothing fires by default
    assign evt_set[`EVT_TRIP_BIT] = flag_nxt && !flag_r;
    assign evt_set[`EVT_RECOVER_BIT] = !flag_nxt && flag_r;
    assign evt_set[`EVT_RESET_BIT] = (state_nxt == MON_TRIPPED) && (state_r == MON_CLEAR);
    assign evt_clr = wr_clr ? pwdata[`EVT_WIDTH-1:0] : '0;

    // sticky status; a set in the clearing cycle survives
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            evt_r <= '0;
        end else begin
            evt_r <= (evt_r & ~evt_clr) | evt_set;
        end
    end

    // event enable register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            evt_en_r <= `EVT_ENABLE_RESET;
        end else if (wr_en) begin
            evt_en_r <= pwdata[`EVT_WIDTH-1:0];
        end
    end

    // level output while any enabled event is pending
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((evt_r & ~evt_clr) | evt_set) & evt_en_r);
        end
    end

    // ---------------- checks ----------------

    sequence trip_seen;
        resets_on && cmp.below_falling;
    endsequence

    sequence reset_follows;
        ##1 reset_req;
    endsequence

    chk_trip_resets: assert property (
        @(posedge mclk) disable iff (!rst_n) trip_seen |-> reset_follows)
        else $error("reset request missing after trip");

    chk_range_trip: assert property (
        @(posedge mclk) disable iff (!rst_n)
        range_new ##4 (resets_on && !cmp.above_rising) |=> reset_req)
        else $error("high range below rising point did not reset");

    chk_reset_holds: assert property (
        @(posedge mclk) disable iff (!rst_n)
        reset_req && resets_on && !cmp.above_rising |=> reset_req)
        else $error("reset request released before rising point");

    chk_reset_disable: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !resets_on |=> !reset_req)
        else $error("reset request while resets are off");

    chk_flag_track: assert property (
        @(posedge mclk) disable iff (!rst_n)
        live && cmp.below_falling |=> undervoltage_flag ##0 flag_r)
        else $error("flag not set below falling point");

    chk_flag_clear: assert property (
        @(posedge mclk) disable iff (!rst_n)
        live && cmp.above_rising && !cmp.below_falling |=> !undervoltage_flag)
        else $error("flag not cleared above rising point");

    chk_flag_frozen: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !live || (!cmp.below_falling && !cmp.above_rising) |=> $stable(flag_r))
        else $error("flag changed while it must hold");

    chk_config_once: assert property (
        @(posedge mclk) disable iff (!rst_n)
        cfg_r.lock |=> $stable(cfg_r))
        else $error("locked configuration changed");

    chk_stop_gate: assert property (
        @(posedge mclk) disable iff (!rst_n)
        stop_mode && !cfg_r.monitor_stop_enable ##1 stop_mode |-> !reset_req && !monitor_enable)
        else $error("monitor active in stop without stop enable");

    chk_wait_runs: assert property (
        @(posedge mclk) disable iff (!rst_n)
        wait_mode && !stop_mode && !cfg_r.monitor_power_disable |=> monitor_enable)
        else $error("monitor stopped in wait mode");

    chk_event_sticky: assert property (
        @(posedge mclk) disable iff (!rst_n)
        evt_r[`EVT_TRIP_BIT] && !evt_clr[`EVT_TRIP_BIT] |=> evt_r[`EVT_TRIP_BIT])
        else $error("trip event lost without a clear");

    chk_apb_answer: assert property (
        @(posedge mclk) disable iff (!rst_n)
        psel && penable && !pready |=> pready)
        else $error("apb answer not on second access cycle");

endmodule

// ### supply_comparator_model.sv
// Purpose: behavioural analog comparator beside the supply monitor
// Assumes: supply level given in millivolts by the bench, thresholds are plain defaults
// Notes: outputs are asynchronous levels; while powered down they carry noise
`timescale 1ns/1ps
module supply_comparator_model #(
    parameter int LO_FALL = 2400,
    parameter int LO_RISE = 2500,
    parameter int HI_FALL = 3900,
    parameter int HI_RISE = 4000
) (
    // clock, only used to make noise while powered down
    input wire logic mclk,
    // control from the monitor
    input wire logic range_select,
    input wire logic monitor_enable,
    // supply level
    input wire logic [15:0] vdd_mv,
    // comparator levels
    output logic below_falling,
    output logic above_rising
);
    logic flip_r = 1'b0;

    // toggling pattern so a disabled comparator never looks like a steady answer
    always @(posedge mclk) begin
        flip_r <= ~flip_r;
    end

    // hysteresis pair; the selected range moves both trip points
    always_comb begin
        if (monitor_enable) begin
            below_falling = int'(vdd_mv) < (range_select ? HI_FALL : LO_FALL);
            above_rising = int'(vdd_mv) > (range_select ? HI_RISE : LO_RISE);
        end else begin
            below_falling = flip_r;
            above_rising = ~flip_r;
        end
    end
endmodule

// ### tb.sv
// Purpose: self-checking bench for the supply monitor
// Assumes: one-wait-state APB slave, comparator levels need about three edges to act
// Notes: config is write-once, so each configuration gets its own reset
`timescale 1ns/1ps
`include "supply_monitor_regs.svh"
module tb;
    localparam logic [15:0] NOM = 16'd5000;
    localparam logic [15:0] TRIP = 16'd2000;
    localparam logic [15:0] MID_LO = 16'd2450;
    localparam logic [15:0] MID_HI = 16'd3950;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, below_falling, above_rising;
    logic wait_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic range_select, monitor_enable, reset_req, undervoltage_flag, irq;
    logic [15:0] vdd_mv = NOM;
    int fail_count = 0;
    int num_checks = 0;

    // 25 MHz clock
    always #20 mclk = ~mclk;

    supply_monitor i_supply_monitor (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .below_falling(below_falling), .above_rising(above_rising),
        .wait_mode(wait_mode), .stop_mode(stop_mode), .range_select(range_select),
        .monitor_enable(monitor_enable), .reset_req(reset_req),
        .undervoltage_flag(undervoltage_flag), .irq(irq));

    supply_comparator_model i_supply_comparator_model (.mclk(mclk),
        .range_select(range_select), .monitor_enable(monitor_enable), .vdd_mv(vdd_mv),
        .below_falling(below_falling), .above_rising(above_rising));

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen high at an edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // pready seen high ends this wait; the watchdog ends it only if pready never comes
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, err});
    endtask

    // comparator path: enable flop, two sync stages, register stage, and one settled cycle
    task automatic settle();
        repeat (6) @(posedge mclk);
    endtask

    task automatic do_reset();
        vdd_mv <= NOM;
        stop_mode <= 1'b0;
        rst_n <= 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        settle();
    endtask

    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        #(40 * 5000);
        fail_count++;
        summarize();
    end

    initial begin
        do_reset();
        // defaults, unmapped access, forced reset with wait mode and events
        rd(`OFS_MON_STATUS, 32'h4, 1'b0);
        rd(`OFS_MON_CONFIG, 32'h0, 1'b0);
        chk(range_select, 1'b0);
        chk(monitor_enable, 1'b1);
        rd(8'h14, 32'h0, 1'b1);
        rd(`OFS_EVT_ENABLE, 32'h0, 1'b0);
        wait_mode <= 1'b1;
        vdd_mv <= TRIP;
        settle();
        chk(reset_req, 1'b1);
        chk(undervoltage_flag, 1'b1);
        chk(irq, 1'b0);
        rd(`OFS_MON_STATUS, 32'h7, 1'b0);
        vdd_mv <= MID_LO;
        settle();
        chk({reset_req, undervoltage_flag}, 2'b11);
        wr(`OFS_EVT_ENABLE, 32'h1);
        settle();
        chk(irq, 1'b1);
        rd(`OFS_EVT_STATUS, 32'h5, 1'b0);
        vdd_mv <= NOM;
        settle();
        chk({reset_req, undervoltage_flag}, 2'b00);
        vdd_mv <= MID_LO;
        settle();
        chk(undervoltage_flag, 1'b0);
        rd(`OFS_EVT_STATUS, 32'h7, 1'b0);
        wr(`OFS_EVT_CLEAR, 32'h7);
        rd(`OFS_EVT_STATUS, 32'h0, 1'b0);
        chk(irq, 1'b0);
        wr(`OFS_MON_STATUS, 32'hff);
        rd(`OFS_MON_STATUS, 32'h4, 1'b0);
        wait_mode <= 1'b0;
        // polled mode: resets off, flag still follows, config locked
        do_reset();
        wr(`OFS_MON_CONFIG, 32'h2);
        rd(`OFS_MON_CONFIG, 32'h12, 1'b0);
        wr(`OFS_MON_CONFIG, 32'h5);
        rd(`OFS_MON_CONFIG, 32'h12, 1'b0);
        chk(range_select, 1'b0);
        vdd_mv <= TRIP;
        settle();
        chk(reset_req, 1'b0);
        chk(undervoltage_flag, 1'b1);
        rd(`OFS_MON_STATUS, 32'h5, 1'b0);
        // power disable: nothing moves
        do_reset();
        wr(`OFS_MON_CONFIG, 32'h1);
        settle();
        chk(monitor_enable, 1'b0);
        vdd_mv <= TRIP;
        settle();
        chk({reset_req, undervoltage_flag}, 2'b00);
        rd(`OFS_MON_STATUS, 32'h0, 1'b0);
        // high range selected while supply sits under its rising point
        do_reset();
        vdd_mv <= MID_HI;
        settle();
        chk(reset_req, 1'b0);
        wr(`OFS_MON_CONFIG, 32'h4);
        settle();
        chk(range_select, 1'b1);
        chk(reset_req, 1'b1);
        vdd_mv <= NOM;
        settle();
        chk(reset_req, 1'b0);
        // stop mode without and with stop enable
        do_reset();
        stop_mode <= 1'b1;
        vdd_mv <= TRIP;
        settle();
        chk(reset_req, 1'b0);
        stop_mode <= 1'b0;
        settle();
        chk(reset_req, 1'b1);
        do_reset();
        wr(`OFS_MON_CONFIG, 32'h8);
        stop_mode <= 1'b1;
        vdd_mv <= TRIP;
        settle();
        chk(reset_req, 1'b1);
        chk(undervoltage_flag, 1'b1);
        summarize();
    end
endmodule
